// File: common/mps_pkg.sv
// mps_pkg: constants, page table and carrier types for the mode sense page reporter
// assumes: single clock domain, byte-wide parameter data stream toward the initiator
package mps_pkg;

	// ------------------------------------------------------------
	// data layout
	// ------------------------------------------------------------
	localparam int          N_PAGES         = 6;
	localparam int          BODY_BYTES      = 80;
	localparam int          HDR_BYTES       = 4;
	localparam int          BD_BYTES        = 8;
	localparam int          PG_HDR_BYTES    = 2;
	localparam logic [7:0]  BD_LEN          = 8'h08;
	localparam logic [7:0]  DENSITY_DEFAULT = 8'h00;
	localparam logic [7:0]  MEDIUM_TYPE     = 8'h00;
	localparam logic [7:0]  RSVD_BYTE       = 8'h00;
	localparam int          WP_BIT          = 7;
	localparam int          PCF_MSB         = 7;
	localparam int          PCF_LSB         = 6;

	// ------------------------------------------------------------
	// page control and page codes
	// ------------------------------------------------------------
	localparam logic [1:0]  PCF_CUR         = 2'h0;
	localparam logic [1:0]  PCF_CHG         = 2'h1;
	localparam logic [1:0]  PCF_DEF         = 2'h2;
	localparam logic [1:0]  PCF_SAV         = 2'h3;
	localparam logic [5:0]  PAGE_OPER       = 6'h00;
	localparam logic [5:0]  PAGE_ERR        = 6'h01;
	localparam logic [5:0]  PAGE_XFER       = 6'h02;
	localparam logic [5:0]  PAGE_FMT        = 6'h03;
	localparam logic [5:0]  PAGE_GEOM       = 6'h04;
	localparam logic [5:0]  PAGE_IDENT      = 6'h20;
	localparam logic [5:0]  PAGE_ALL        = 6'h3f;

	// implemented pages in ascending code order
	function automatic logic [5:0] pg_code(input int i);
		case (i)
			0:       pg_code = PAGE_OPER;
			1:       pg_code = PAGE_ERR;
			2:       pg_code = PAGE_XFER;
			3:       pg_code = PAGE_FMT;
			4:       pg_code = PAGE_GEOM;
			default: pg_code = PAGE_IDENT;
		endcase
	endfunction

	// page length byte; format and geometry have no changeable field
	function automatic logic [7:0] pg_len(input int i, input logic chg);
		case (i)
			0:       pg_len = 8'h02;
			1:       pg_len = 8'h06;
			2:       pg_len = 8'h0a;
			3:       pg_len = chg ? 8'h00 : 8'h16;
			4:       pg_len = chg ? 8'h00 : 8'h10;
			default: pg_len = 8'h18;
		endcase
	endfunction

	// start of each page body in the store
	function automatic logic [6:0] pg_base(input int i);
		case (i)
			0:       pg_base = 7'h00;
			1:       pg_base = 7'h02;
			2:       pg_base = 7'h08;
			3:       pg_base = 7'h12;
			4:       pg_base = 7'h28;
			default: pg_base = 7'h38;
		endcase
	endfunction

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  page_control_field;
		logic [5:0]  page_code;
		logic [7:0]  alloc_len;
	} mps_cmd_s;

	typedef struct packed {
		logic [23:0] blk_count;
		logic [23:0] blk_len;
		logic        wp;
	} mps_unit_s;

	typedef struct packed {
		logic        we;
		logic [6:0]  addr;
		logic [7:0]  data;
	} mps_wr_s;

	typedef struct packed {
		logic [7:0]  cur;
		logic [7:0]  saved;
		logic [7:0]  dflt;
		logic [7:0]  chg;
	} mps_src_s;

endpackage

// File: core/mps_page_store.sv
// mps_page_store: byte memory holding current page values, registered read data
// assumes: one write port and one read port on the same clock
`timescale 1ns/1ps
module mps_page_store #(
	parameter int DEPTH = 80,
	parameter int AW    = 7
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// read port
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_nxt;

	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("page store depth exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (we && (int'(waddr) < DEPTH)) mem[waddr] <= wdata;
	end

	always_comb begin
		rdata_nxt = rdata;
		if (re) rdata_nxt = (int'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rdata <= 8'h00;
		else        rdata <= rdata_nxt;
	end

endmodule

// File: core/mps_reporter.sv
// mps_reporter: builds mode sense parameter data as a byte stream
// assumes: commands and store writes come from logic on clk; page sources answer lut_addr in the same cycle
//
// What this block does
// R1 - density code byte is always zero
// R2 - block count three bytes, msb first
// R3 - reserved byte, then block length msb first
// R4 - page code byte, length byte, then body
// R5 - recognise pages 0h-4h; reserved codes ignored
// R6 - page 20h carries vendor and product strings
// R7 - code 3fh returns every implemented page
// R8 - page control from cdb byte 2 bits 7:6
// R9 - current control with 3fh: all pages current
// R10 - current control otherwise: addressed supported page only
// R11 - current: last mode select, else saved, else default
// R12 - unsupported bits zero; length marks supported extent
// R13 - changeable control: changeable bits one, others zero
// R14 - page without changeable bits wholly omitted
// R15 - stop at allocation length or data end
// R16 - header, block descriptor, then page descriptors
// R17 - all pages ascending, packed without padding
`timescale 1ns/1ps
module mps_reporter (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// command
	input  wire logic              cmd_valid,
	input  wire mps_pkg::mps_cmd_s cmd,
	output logic                   cmd_ready,
	output logic                   done,
	// unit state
	input  wire mps_pkg::mps_unit_s unit,
	input  wire logic              saved_avail,
	// mode select side
	input  wire mps_pkg::mps_wr_s  sel_wr,
	input  wire logic              sel_commit,
	// page value sources
	output logic [6:0]             lut_addr,
	input  wire logic [7:0]        saved_byte,
	input  wire logic [7:0]        dflt_byte,
	input  wire logic [7:0]        chg_byte,
	// parameter data stream
	output logic                   out_valid,
	output logic [7:0]             out_data,
	output logic                   out_last,
	input  wire logic              out_ready
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_BD, ST_PCODE, ST_PLEN, ST_PRD, ST_PBODY} mps_state_e;

	mps_state_e        st_r, st_nxt;
	mps_pkg::mps_cmd_s cmd_r, cmd_nxt;
	logic [6:0]        cnt_r, cnt_nxt;
	logic [2:0]        pg_r, pg_nxt;
	logic [7:0]        sent_r, sent_nxt;
	logic [7:0]        limit_r, limit_nxt;
	logic [7:0]        total_r, total_nxt;
	logic              sel_seen_r, sel_seen_nxt;
	logic              zdone_r, zdone_nxt;
	logic [6:0]        lut_addr_nxt;
	logic              ov_r, ov_nxt;
	logic [7:0]        od_r, od_nxt;
	logic              ol_r, ol_nxt;

	logic              slot_free;
	logic              emit;
	logic [7:0]        emit_byte;
	logic              rd_en;
	logic [6:0]        rd_addr;
	logic [7:0]        store_byte;
	logic              chg_q;
	logic [2:0]        first_pg, next_pg;
	logic [7:0]        acc;
	logic              cur_chg;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	localparam int MAX_TOTAL = mps_pkg::HDR_BYTES + mps_pkg::BD_BYTES + mps_pkg::BODY_BYTES
		+ mps_pkg::N_PAGES * mps_pkg::PG_HDR_BYTES;

	// page index needs one spare code as the no-more-pages marker
	if (mps_pkg::N_PAGES > 7) begin : g_bad_pages
		$error("page count does not fit the page index");
	end

	if (mps_pkg::BODY_BYTES > 128) begin : g_bad_body
		$error("page store does not fit the body address");
	end

	// byte counters and the sense length byte are eight bits wide
	if (MAX_TOTAL > 255) begin : g_bad_total
		$error("response does not fit the length byte");
	end

	if (mps_pkg::HDR_BYTES != 4 || mps_pkg::BD_BYTES != 8) begin : g_bad_fixed
		$error("header and descriptor decode assume four and eight bytes");
	end

	// ------------------------------------------------------------
	// page selection
	// ------------------------------------------------------------
	function automatic logic incl(input int i, input mps_pkg::mps_cmd_s c);
		logic chg;
		logic hit;
		chg  = (c.page_control_field == mps_pkg::PCF_CHG);
		hit  = (c.page_code == mps_pkg::PAGE_ALL) || (c.page_code == mps_pkg::pg_code(i)); // R5 R7 R9 R10
		incl = hit && (mps_pkg::pg_len(i, chg) != 8'h00); // R14
	endfunction

	always_comb begin
		first_pg = 3'(mps_pkg::N_PAGES);
		next_pg  = 3'(mps_pkg::N_PAGES);
		acc      = 8'(mps_pkg::HDR_BYTES + mps_pkg::BD_BYTES); // R16
		cur_chg  = (cmd.page_control_field == mps_pkg::PCF_CHG);
		for (int i = mps_pkg::N_PAGES - 1; i >= 0; i--) begin
			if (incl(i, cmd)) first_pg = 3'(i); // R17
			if (incl(i, cmd_r) && (i > int'(pg_r))) next_pg = 3'(i); // R17
		end
		for (int i = 0; i < mps_pkg::N_PAGES; i++) begin
			if (incl(i, cmd)) acc = 8'(acc + mps_pkg::PG_HDR_BYTES + mps_pkg::pg_len(i, cur_chg));
		end
	end

	// ------------------------------------------------------------
	// byte source
	// ------------------------------------------------------------
	assign chg_q = (cmd_r.page_control_field == mps_pkg::PCF_CHG);

	always_comb begin
		emit_byte = mps_pkg::RSVD_BYTE;
		case (st_r)
			ST_HDR: begin
				case (cnt_r[1:0])
					2'h0:    emit_byte = 8'(total_r - 8'h01);
					2'h1:    emit_byte = mps_pkg::MEDIUM_TYPE;
					2'h2:    emit_byte = 8'(unit.wp) << mps_pkg::WP_BIT;
					default: emit_byte = mps_pkg::BD_LEN;
				endcase
			end
			ST_BD: begin
				case (cnt_r[2:0])
					3'h0:    emit_byte = mps_pkg::DENSITY_DEFAULT; // R1
					3'h1:    emit_byte = unit.blk_count[23:16]; // R2
					3'h2:    emit_byte = unit.blk_count[15:8]; // R2
					3'h3:    emit_byte = unit.blk_count[7:0]; // R2
					3'h4:    emit_byte = mps_pkg::RSVD_BYTE; // R3
					3'h5:    emit_byte = unit.blk_len[23:16]; // R3
					3'h6:    emit_byte = unit.blk_len[15:8]; // R3
					default: emit_byte = unit.blk_len[7:0]; // R3
				endcase
			end
			ST_PCODE: emit_byte = {2'h0, mps_pkg::pg_code(int'(pg_r))}; // R4 R6
			ST_PLEN:  emit_byte = mps_pkg::pg_len(int'(pg_r), chg_q); // R4 R12
			ST_PBODY: begin
				case (cmd_r.page_control_field)
					mps_pkg::PCF_CUR: emit_byte = sel_seen_r ? store_byte : (saved_avail ? saved_byte : dflt_byte); // R11 R12
					mps_pkg::PCF_CHG: emit_byte = chg_byte; // R13
					mps_pkg::PCF_DEF: emit_byte = dflt_byte;
					default:          emit_byte = saved_avail ? saved_byte : dflt_byte;
				endcase
			end
			default: emit_byte = mps_pkg::RSVD_BYTE;
		endcase
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	assign slot_free = !ov_r || out_ready;
	assign emit      = slot_free && (st_r != ST_IDLE) && (st_r != ST_PRD);

	always_comb begin
		st_nxt       = st_r;
		cmd_nxt      = cmd_r;
		cnt_nxt      = cnt_r;
		pg_nxt       = pg_r;
		sent_nxt     = sent_r;
		limit_nxt    = limit_r;
		total_nxt    = total_r;
		zdone_nxt    = 1'b0;
		lut_addr_nxt = lut_addr;
		rd_en        = 1'b0;
		rd_addr      = 7'(mps_pkg::pg_base(int'(pg_r)) + cnt_r);
		ov_nxt       = ov_r && !out_ready;
		od_nxt       = od_r;
		ol_nxt       = ol_r && !(ov_r && out_ready);
		case (st_r)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					cmd_nxt   = cmd; // R8
					total_nxt = acc;
					limit_nxt = (cmd.alloc_len < acc) ? cmd.alloc_len : acc; // R15
					pg_nxt    = first_pg;
					cnt_nxt   = 7'h00;
					sent_nxt  = 8'h00;
					if (cmd.alloc_len == 8'h00) zdone_nxt = 1'b1; // R15
					else                        st_nxt    = ST_HDR; // R16
				end
			end
			ST_PRD: begin
				rd_en        = 1'b1;
				lut_addr_nxt = rd_addr;
				st_nxt       = ST_PBODY;
			end
			default: begin
				if (emit) begin
					ov_nxt   = 1'b1;
					od_nxt   = emit_byte;
					ol_nxt   = (8'(sent_r + 8'h01) == limit_r);
					sent_nxt = 8'(sent_r + 8'h01);
					cnt_nxt  = 7'(cnt_r + 7'h01);
					case (st_r)
						ST_HDR: if (cnt_r == 7'(mps_pkg::HDR_BYTES - 1)) begin
							st_nxt  = ST_BD;
							cnt_nxt = 7'h00;
						end
						ST_BD: if (cnt_r == 7'(mps_pkg::BD_BYTES - 1)) begin
							st_nxt  = (int'(pg_r) < mps_pkg::N_PAGES) ? ST_PCODE : ST_IDLE; // R16
							cnt_nxt = 7'h00;
						end
						ST_PCODE: st_nxt = ST_PLEN; // R4
						ST_PLEN: begin
							cnt_nxt = 7'h00;
							st_nxt  = ST_PRD; // R4
						end
						default: begin
							if (8'(cnt_r + 7'h01) < mps_pkg::pg_len(int'(pg_r), chg_q)) begin
								st_nxt = ST_PRD;
							end else begin
								pg_nxt  = next_pg; // R17
								cnt_nxt = 7'h00;
								st_nxt  = (int'(next_pg) < mps_pkg::N_PAGES) ? ST_PCODE : ST_IDLE;
							end
						end
					endcase
					if (8'(sent_r + 8'h01) == limit_r) st_nxt = ST_IDLE; // R15
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r     <= ST_IDLE;
			cmd_r    <= '0;
			cnt_r    <= 7'h00;
			pg_r     <= 3'h0;
			sent_r   <= 8'h00;
			limit_r  <= 8'h00;
			total_r  <= 8'h00;
			zdone_r  <= 1'b0;
			lut_addr <= 7'h00;
			ov_r     <= 1'b0;
			od_r     <= 8'h00;
			ol_r     <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			cmd_r    <= cmd_nxt;
			cnt_r    <= cnt_nxt;
			pg_r     <= pg_nxt;
			sent_r   <= sent_nxt;
			limit_r  <= limit_nxt;
			total_r  <= total_nxt;
			zdone_r  <= zdone_nxt;
			lut_addr <= lut_addr_nxt;
			ov_r     <= ov_nxt;
			od_r     <= od_nxt;
			ol_r     <= ol_nxt;
		end
	end

	// ------------------------------------------------------------
	// current value tracking
	// ------------------------------------------------------------
	always_comb begin
		sel_seen_nxt = sel_seen_r || sel_commit; // R11
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) sel_seen_r <= 1'b0;
		else        sel_seen_r <= sel_seen_nxt;
	end

	mps_page_store #(
		.DEPTH (mps_pkg::BODY_BYTES),
		.AW    (7)
	) u_store (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (sel_wr.we),
		.waddr (sel_wr.addr),
		.wdata (sel_wr.data),
		.re    (rd_en),
		.raddr (rd_addr),
		.rdata (store_byte)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_ready = (st_r == ST_IDLE) && !ov_r && !zdone_r;
	assign done      = zdone_r || (ov_r && out_ready && ol_r); // R15
	assign out_valid = ov_r;
	assign out_data  = od_r;
	assign out_last  = ol_r;

endmodule

// File: bench/mps_reporter_monitor.sv
// mps_reporter_monitor: port checks for the mode sense reporter
// assumes: bound to mps_reporter, one clock, async active-low reset
`timescale 1ns/1ps
module mps_reporter_monitor (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// command
	input wire logic              cmd_valid,
	input wire mps_pkg::mps_cmd_s cmd,
	input wire logic              cmd_ready,
	input wire logic              done,
	// stream
	input wire logic              out_valid,
	input wire logic [7:0]        out_data,
	input wire logic              out_last,
	input wire logic              out_ready
);
	logic [7:0] cnt_r, cnt_nxt, lim_r, lim_nxt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// bytes sent since the last command
	// ------------------------------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		lim_nxt = lim_r;
		if (cmd_valid && cmd_ready) begin
			cnt_nxt = 8'h00;
			lim_nxt = cmd.alloc_len;
		end else if (out_valid && out_ready) begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			lim_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
			lim_r <= lim_nxt;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
		else $error("output byte changed before acceptance");
	a_alloc_cap: assert property (out_valid && out_ready |-> cnt_r < lim_r)
		else $error("byte sent beyond allocation length");
	a_zero_alloc: assert property (cmd_valid && cmd_ready && cmd.alloc_len == 8'h00 |=> done && !out_valid)
		else $error("zero allocation did not finish at once");
	a_first_byte: assert property (cmd_valid && cmd_ready && cmd.alloc_len != 8'h00 |=> !done ##1 out_valid)
		else $error("first byte not offered after take");
	a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("command accepted while busy");
	a_done_last: assert property (out_valid && out_ready && out_last |-> done ##1 cmd_ready)
		else $error("last byte without done or return to idle");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_idle_quiet: assert property (cmd_ready |-> !out_valid && !out_last)
		else $error("stream active while idle");
endmodule

bind mps_reporter mps_reporter_monitor u_mon (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
	.cmd_ready(cmd_ready), .done(done), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
	.out_ready(out_ready));

// File: bench/mps_initiator_model.sv
// mps_initiator_model: byte sink in the place of the initiator
// assumes: stream handshake on clk; stall throttles acceptance to one cycle in three
`timescale 1ns/1ps
module mps_initiator_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// bench control
	input wire logic       stall,
	// stream
	input wire logic       out_valid,
	input wire logic [7:0] out_data,
	input wire logic       out_last,
	output logic           out_ready
);
	logic [7:0] got [0:127];
	int         n;
	int         lastn;
	int         tick;

	initial begin
		out_ready = 1'b0;
		n = 0;
		lastn = 0;
		tick = 0;
	end
	always @(posedge clk) begin
		tick <= tick + 1;
		out_ready <= rst_n && (!stall || tick % 3 == 0);
		if (out_valid && out_ready) begin
			got[n] <= out_data;
			n <= n + 1;
			if (out_last) lastn <= n;
		end
	end
endmodule

// File: bench/mps_reporter_test.sv
// mps_reporter_test: directed mode sense requests checked byte by byte
// assumes: mps_pkg compiled first; initiator model and monitor alongside
`timescale 1ns/1ps
module mps_reporter_test;
	logic               clk, rst_n, cmd_valid, cmd_ready, done, saved_avail, sel_commit;
	logic               out_valid, out_last, out_ready, stall, committed;
	logic [6:0]         lut_addr;
	logic [7:0]         out_data, saved_byte, dflt_byte, chg_byte;
	mps_pkg::mps_cmd_s  cmd;
	mps_pkg::mps_unit_s unit;
	mps_pkg::mps_wr_s   sel_wr;
	int                 bad_count, total_checks, k;
	logic [7:0]         exp [$];
	logic [5:0]         pcode [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h20};
	logic [7:0]         plen [6]  = '{8'h02, 8'h06, 8'h0a, 8'h16, 8'h10, 8'h18};
	logic [6:0]         pbase [6] = '{7'h00, 7'h02, 7'h08, 7'h12, 7'h28, 7'h38};
	logic [5:0]         one [8]   = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h1f, 6'h20, 6'h21, 6'h3e};

	assign saved_byte = {1'b0, lut_addr} ^ 8'h5a;
	assign dflt_byte = {1'b0, lut_addr} + 8'h10;
	assign chg_byte = ~{1'b0, lut_addr};

	mps_reporter u_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
		.done(done), .unit(unit), .saved_avail(saved_avail), .sel_wr(sel_wr), .sel_commit(sel_commit),
		.lut_addr(lut_addr), .saved_byte(saved_byte), .dflt_byte(dflt_byte), .chg_byte(chg_byte),
		.out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
	mps_initiator_model u_init (.clk(clk), .rst_n(rst_n), .stall(stall), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// expected data and request tasks
	// ------------------------------------------------------------
	function automatic logic [7:0] val(input logic [1:0] pc, input logic [6:0] a);
		if (pc == 2'h1) return ~{1'b0, a};
		if (pc == 2'h0 && committed) return {1'b0, a} ^ 8'hc3;
		if (pc != 2'h2 && saved_avail) return {1'b0, a} ^ 8'h5a;
		return {1'b0, a} + 8'h10;
	endfunction

	task automatic build(input logic [1:0] pc, input logic [5:0] code, input logic [7:0] alloc);
		int i, j;
		exp = '{8'h00, 8'h00, {unit.wp, 7'h00}, 8'h08, 8'h00, unit.blk_count[23:16], unit.blk_count[15:8],
			unit.blk_count[7:0], 8'h00, unit.blk_len[23:16], unit.blk_len[15:8], unit.blk_len[7:0]};
		for (i = 0; i < 6; i++) begin
			if ((code == 6'h3f || code == pcode[i]) && !(pc == 2'h1 && (i == 3 || i == 4))) begin
				exp.push_back({2'h0, pcode[i]});
				exp.push_back(plen[i]);
				for (j = 0; j < plen[i]; j++) exp.push_back(val(pc, pbase[i] + 7'(j)));
			end
		end
		exp[0] = 8'(exp.size() - 1);
		while (exp.size() > alloc) exp.pop_back();
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic run(input logic [1:0] pc, input logic [5:0] code, input logic [7:0] alloc, input logic st);
		int i;
		build(pc, code, alloc);
		stall = st;
		u_init.n = 0;
		u_init.lastn = -1;
		cmd = '{pc, code, alloc};
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 900 && done !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		chk("done", 8'(i < 900), 8'h01);
		chk("byte count", 8'(u_init.n), 8'(exp.size()));
		for (i = 0; i < exp.size(); i++) chk("data byte", u_init.got[i], exp[i]);
		if (exp.size() > 0) chk("last flag", 8'(u_init.lastn), 8'(exp.size() - 1));
	endtask

	task automatic summarize;
		if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		unit = '{24'h012345, 24'h000200, 1'b1};
		saved_avail = 1'b0;
		sel_wr = '0;
		sel_commit = 1'b0;
		stall = 1'b0;
		committed = 1'b0;
		bad_count = 0;
		total_checks = 0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		run(2'h0, 6'h3f, 8'hff, 1'b0);
		saved_avail = 1'b1;
		run(2'h0, 6'h3f, 8'hff, 1'b1);
		run(2'h1, 6'h3f, 8'hff, 1'b1);
		run(2'h1, 6'h03, 8'hff, 1'b0);
		run(2'h2, 6'h3f, 8'hff, 1'b0);
		run(2'h3, 6'h02, 8'hff, 1'b0);
		for (k = 0; k < 8; k++) run(2'h0, one[k], 8'hff, 1'b0);
		run(2'h0, 6'h3f, 8'h00, 1'b0);
		run(2'h0, 6'h3f, 8'h0d, 1'b1);
		unit = '{24'h000000, 24'h000000, 1'b0};
		run(2'h0, 6'h20, 8'hff, 1'b0);
		for (k = 0; k < 80; k++) begin
			sel_wr = '{1'b1, 7'(k), 8'(k) ^ 8'hc3};
			@(negedge clk);
		end
		sel_wr = '0;
		sel_commit = 1'b1;
		@(negedge clk);
		sel_commit = 1'b0;
		committed = 1'b1;
		run(2'h0, 6'h3f, 8'hff, 1'b1);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		committed = 1'b0;
		@(negedge clk);
		run(2'h0, 6'h3f, 8'hff, 1'b0);
		summarize();
	end

	initial begin
		#100000;
		bad_count++;
		summarize();
	end
endmodule
